// >>> design/nss_pkg.sv
/*
  Shared constants and carriers for the settings save and restore controller.
  Assumes a byte-wide register port and a byte-wide buffer register bank port.
*/
package nss_pkg;
  // Register byte addresses in the serial port's register space.
  localparam logic [11:0] ADDR_STATUS_PIN_CFG = 12'h01d;
  localparam logic [11:0] ADDR_UPDATE = 12'h232;
  localparam logic [11:0] ADDR_NVM_STATUS = 12'hb00;
  localparam logic [11:0] ADDR_NVM_ERROR = 12'hb01;
  localparam logic [11:0] ADDR_NVM_CONTROL = 12'hb02;
  localparam logic [11:0] ADDR_NVM_SAVE = 12'hb03;
  // Field positions.
  localparam int BIT_BUSY = 0;
  localparam int BIT_ERROR = 0;
  localparam int BIT_WRITE_EN = 0;
  localparam int BIT_SOFT_RESET = 1;
  localparam int BIT_SAVE = 0;
  localparam int BIT_UPDATE = 0;
  localparam int BIT_PIN_SEL = 7;
  localparam int BIT_OPCODE = 7;
  // Buffer segment placement and operation codes.
  localparam logic [7:0] SEG_PAGE = 8'h0a;
  localparam logic [7:0] SEG_LAST = 8'hff;
  localparam logic [7:0] OP_UPDATE = 8'h80;
  localparam logic [7:0] OP_END = 8'hff;
  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic RESET_WRITE_EN = 1'b0;
  // Store geometry default.
  localparam int NVM_AW_DEF = 9;
  // Gap the host keeps between transfers, and its length in clock cycles.
  localparam int CLK_MHZ = 20;
  localparam int GAP_US = 10;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;

  // One access on the register port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } nss_reg_req_t;

  // One access on the buffer register bank port.
  typedef struct packed {
    logic rd;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } nss_buf_req_t;
endpackage

// >>> design/nss_nvm_mem.sv
/*
  Byte-wide single port memory that models the nonvolatile store.
  Assumes the controller never reads and writes in the same cycle.
*/
module nss_nvm_mem #(
  parameter int AW = 9
) (
  // Clock.
  input wire logic clk_i,
  // Access.
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [2**AW];

  // Write port and registered read port.
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
    if (re_i)
    begin
      rdata_o <= mem_q[addr_i];
    end
  end
endmodule

// >>> design/nss_nvm_ctrl.sv
/*
  Control and status of the nonvolatile settings store: save, restore, soft
  reset, write protection, busy and error flags, and the status pin source.
  Assumes the register port gives single-cycle strobes and that the buffer
  bank returns read data in the cycle after its read strobe.
*/
module nss_nvm_ctrl #(
  parameter int NVM_AW = nss_pkg::NVM_AW_DEF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire nss_pkg::nss_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Pins.
  input wire logic nvm_sel_b_i,
  input wire logic status_alt_i,
  output logic status_pin_o,
  // Buffer register bank.
  output nss_pkg::nss_buf_req_t buf_req_o,
  input wire logic [7:0] buf_rdata_i,
  // Device events.
  output logic update_o,
  output logic soft_rst_o
);
  import nss_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WAIT, ST_TAKE} nss_state_t;
  typedef enum logic [2:0] {PH_CMD, PH_AH, PH_AL, PH_DAT, PH_SUM} nss_phase_t;

  nss_state_t state_ff;
  nss_phase_t phase_ff;
  logic save_dir_ff;
  logic [7:0] seg_ptr_ff;
  logic [15:0] dat_ptr_ff;
  logic [6:0] cnt_ff;
  logic [NVM_AW-1:0] nvm_ptr_ff;
  logic [7:0] sum_ff;
  logic err_ff;
  logic write_en_ff;
  logic pin_sel_ff;
  logic save_bit_ff;
  logic soft_bit_ff;
  logic [7:0] mem_rdata;
  logic [7:0] byte_in;
  logic [15:0] bank_addr;
  logic idle;
  logic start_save;
  logic start_load;
  logic upd_wr;
  logic fault;
  logic finish;

  // Request decode.
  assign idle = (state_ff == ST_IDLE);
  assign start_save = reg_req_i.wr && reg_req_i.addr == ADDR_NVM_SAVE &&
                      reg_req_i.wdata[BIT_SAVE] && write_en_ff && idle;
  assign start_load = reg_req_i.wr && reg_req_i.addr == ADDR_NVM_CONTROL &&
                      reg_req_i.wdata[BIT_SOFT_RESET] && !nvm_sel_b_i && idle;
  assign upd_wr = reg_req_i.wr && reg_req_i.addr == ADDR_UPDATE &&
                  reg_req_i.wdata[BIT_UPDATE];

  // Byte moving through the engine and the bank address it belongs to.
  assign byte_in = save_dir_ff ? ((phase_ff == PH_SUM) ? sum_ff : buf_rdata_i) : mem_rdata;
  assign bank_addr = (phase_ff == PH_DAT) ? dat_ptr_ff : {SEG_PAGE, seg_ptr_ff};

  // Abort on store overflow or a segment that runs out without end of data.
  assign fault = (phase_ff != PH_SUM && nvm_ptr_ff == '1) ||
                 (phase_ff == PH_CMD && seg_ptr_ff == SEG_LAST && byte_in != OP_END);
  assign finish = (state_ff == ST_TAKE) && (phase_ff == PH_SUM || fault);

  nss_nvm_mem #(
    .AW(NVM_AW)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(state_ff == ST_TAKE && save_dir_ff),
    .re_i(state_ff == ST_READ && !save_dir_ff),
    .addr_i(nvm_ptr_ff),
    .wdata_i(byte_in),
    .rdata_o(mem_rdata)
  );

  // Transfer sequencer; a new start is accepted whenever idle.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_ff <= ST_IDLE;
      save_dir_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (start_save || start_load)
          begin
            state_ff <= ST_READ;
            save_dir_ff <= start_save;
          end
        end
        ST_READ: state_ff <= ST_WAIT;
        ST_WAIT: state_ff <= ST_TAKE;
        ST_TAKE: state_ff <= finish ? ST_IDLE : ST_READ;
      endcase
    end
  end

  // Stream decode: commands, addresses, data and the closing checksum.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      phase_ff <= PH_CMD;
      seg_ptr_ff <= RESET_BYTE;
      dat_ptr_ff <= '0;
      cnt_ff <= '0;
      nvm_ptr_ff <= '0;
      sum_ff <= RESET_BYTE;
    end
    else if (idle)
    begin
      phase_ff <= PH_CMD;
      seg_ptr_ff <= RESET_BYTE;
      nvm_ptr_ff <= '0;
      sum_ff <= RESET_BYTE;
    end
    else if (state_ff == ST_TAKE && !finish)
    begin
      nvm_ptr_ff <= nvm_ptr_ff + 1'b1;
      sum_ff <= sum_ff + byte_in;
      if (phase_ff != PH_DAT)
      begin
        seg_ptr_ff <= seg_ptr_ff + 1'b1;
      end
      unique case (phase_ff)
        PH_CMD:
        begin
          if (!byte_in[BIT_OPCODE])
          begin
            cnt_ff <= byte_in[6:0];
            phase_ff <= PH_AH;
          end
          else if (byte_in == OP_END)
          begin
            phase_ff <= PH_SUM;
          end
        end
        PH_AH:
        begin
          dat_ptr_ff[15:8] <= byte_in;
          phase_ff <= PH_AL;
        end
        PH_AL:
        begin
          dat_ptr_ff[7:0] <= byte_in;
          phase_ff <= PH_DAT;
        end
        PH_DAT:
        begin
          dat_ptr_ff <= dat_ptr_ff + 1'b1;
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_ff == '0)
          begin
            phase_ff <= PH_CMD;
          end
        end
        PH_SUM: phase_ff <= PH_SUM;
      endcase
    end
  end

  // Error flag: cleared at each start, set by a fault or a checksum mismatch.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      err_ff <= 1'b0;
    end
    else if (start_save || start_load)
    begin
      err_ff <= 1'b0;
    end
    else if (state_ff == ST_TAKE)
    begin
      if (fault || (phase_ff == PH_SUM && !save_dir_ff && byte_in != sum_ff))
      begin
        err_ff <= 1'b1;
      end
    end
  end

  // Buffer bank strobes: reads during save, writes during restore.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      buf_req_o <= '0;
    end
    else
    begin
      buf_req_o.rd <= (state_ff == ST_READ) && save_dir_ff && (phase_ff != PH_SUM);
      buf_req_o.we <= (state_ff == ST_TAKE) && !save_dir_ff && !finish;
      if (state_ff == ST_READ || state_ff == ST_TAKE)
      begin
        buf_req_o.addr <= bank_addr;
      end
      buf_req_o.wdata <= byte_in;
    end
  end

  // Update and soft reset pulses.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      update_o <= 1'b0;
      soft_rst_o <= 1'b0;
    end
    else
    begin
      update_o <= upd_wr || (state_ff == ST_TAKE && !save_dir_ff &&
                  phase_ff == PH_CMD && byte_in == OP_UPDATE);
      soft_rst_o <= start_load;
    end
  end

  // Software bits; trigger bits stay set until their transfer ends.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      write_en_ff <= RESET_WRITE_EN;
      pin_sel_ff <= 1'b0;
      save_bit_ff <= 1'b0;
      soft_bit_ff <= 1'b0;
    end
    else
    begin
      if (reg_req_i.wr && reg_req_i.addr == ADDR_NVM_CONTROL)
      begin
        write_en_ff <= reg_req_i.wdata[BIT_WRITE_EN];
      end
      if (reg_req_i.wr && reg_req_i.addr == ADDR_STATUS_PIN_CFG)
      begin
        pin_sel_ff <= reg_req_i.wdata[BIT_PIN_SEL];
      end
      if (start_save)
      begin
        save_bit_ff <= 1'b1;
      end
      else if (finish)
      begin
        save_bit_ff <= 1'b0;
      end
      if (start_load)
      begin
        soft_bit_ff <= 1'b1;
      end
      else if (finish)
      begin
        soft_bit_ff <= 1'b0;
      end
    end
  end

  // Status pin source and register read data.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      status_pin_o <= 1'b0;
      reg_rdata_o <= RESET_BYTE;
    end
    else
    begin
      status_pin_o <= pin_sel_ff ? !idle : status_alt_i;
      if (reg_req_i.rd)
      begin
        reg_rdata_o <= RESET_BYTE;
        unique case (reg_req_i.addr)
          ADDR_NVM_STATUS: reg_rdata_o[BIT_BUSY] <= !idle;
          ADDR_NVM_ERROR: reg_rdata_o[BIT_ERROR] <= err_ff;
          ADDR_NVM_CONTROL:
          begin
            reg_rdata_o[BIT_WRITE_EN] <= write_en_ff;
            reg_rdata_o[BIT_SOFT_RESET] <= soft_bit_ff;
          end
          ADDR_NVM_SAVE: reg_rdata_o[BIT_SAVE] <= save_bit_ff;
          ADDR_STATUS_PIN_CFG: reg_rdata_o[BIT_PIN_SEL] <= pin_sel_ff;
          default: reg_rdata_o <= RESET_BYTE;
        endcase
      end
    end
  end
endmodule

// >>> sim/nss_buf_bank.sv
/*
  Buffer register bank model for the bench.
  Assumes at most one strobe per cycle from the controller.
*/
module nss_buf_bank
  import nss_pkg::*;
(
  // Clock and bank port.
  input wire logic clk_i,
  input wire nss_pkg::nss_buf_req_t buf_req_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:4095];
  // The bank starts cleared.
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    rdata_o = 8'h5a;
  end
  // Reads answer a cycle later; otherwise the line flips so stale data is never taken.
  always @(posedge clk_i)
  begin
    if (buf_req_i.we) mem[buf_req_i.addr[11:0]] <= buf_req_i.wdata;
    if (buf_req_i.rd) rdata_o <= mem[buf_req_i.addr[11:0]];
    else rdata_o <= ~rdata_o;
  end
endmodule

// >>> sim/nss_nvm_chk.sv
/*
  Port checker for the store controller.
  Assumes it is bound to every controller instance.
*/
module nss_nvm_chk
  import nss_pkg::*;
(
  // Watched ports.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire nss_pkg::nss_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic nvm_sel_b_i,
  input wire logic status_alt_i,
  input wire logic status_pin_o,
  input wire nss_pkg::nss_buf_req_t buf_req_o,
  input wire logic update_o,
  input wire logic soft_rst_o
);
  logic pin_sel_ff;
  logic wen_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Shadow copies of the pin select and write enable bits.
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) pin_sel_ff <= 1'b0;
    else if (reg_req_i.wr && reg_req_i.addr == ADDR_STATUS_PIN_CFG) pin_sel_ff <= reg_req_i.wdata[7];
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) wen_ff <= 1'b0;
    else if (reg_req_i.wr && reg_req_i.addr == ADDR_NVM_CONTROL) wen_ff <= reg_req_i.wdata[0];
  sequence s_save;
    reg_req_i.wr && reg_req_i.addr == ADDR_NVM_SAVE && reg_req_i.wdata[0];
  endsequence
  sequence s_reload;
    reg_req_i.wr && reg_req_i.addr == ADDR_NVM_CONTROL && reg_req_i.wdata[1];
  endsequence
  sequence s_save_ok;
    s_save ##0 (wen_ff && pin_sel_ff && !status_pin_o);
  endsequence
  AST_PIN_ALT: assert property (!pin_sel_ff |=> status_pin_o == $past(status_alt_i))
    else $error("status pin does not follow the alternate source");
  AST_STATUS_UNUSED: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_NVM_STATUS
    |=> reg_rdata_o[7:1] == 7'h00)
    else $error("status register unused bits set");
  AST_ERROR_UNUSED: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_NVM_ERROR
    |=> reg_rdata_o[7:1] == 7'h00)
    else $error("error register unused bits set");
  AST_UPDATE: assert property (reg_req_i.wr && reg_req_i.addr == ADDR_UPDATE
    && reg_req_i.wdata[0] |=> update_o)
    else $error("update write gave no update pulse");
  AST_UPDATE_ONE: assert property (update_o |=> !update_o)
    else $error("update pulse too long");
  AST_SOFT_ONE: assert property (soft_rst_o |=> !soft_rst_o)
    else $error("soft reset pulse too long");
  AST_RELOAD_BLOCKED: assert property (s_reload ##0 nvm_sel_b_i |=> !soft_rst_o [*4])
    else $error("reload started with select high");
  AST_RELOAD: assert property (s_reload ##0 (!nvm_sel_b_i && pin_sel_ff && !status_pin_o)
    |=> soft_rst_o)
    else $error("reload request gave no soft reset");
  AST_WP_SAVE: assert property (s_save ##0 !wen_ff |=> !buf_req_o.rd [*8])
    else $error("protected save read the bank");
  AST_SAVE_BUSY: assert property (s_save_ok |-> ##[1:3] status_pin_o)
    else $error("save did not raise busy");
  AST_SAVE_READS: assert property (s_save_ok |-> ##[1:6] buf_req_o.rd)
    else $error("save did not read the bank");
endmodule

bind nss_nvm_ctrl nss_nvm_chk u_nss_nvm_chk (.clk_i, .rst_b_i, .reg_req_i, .reg_rdata_o,
  .nvm_sel_b_i, .status_alt_i, .status_pin_o, .buf_req_o, .update_o, .soft_rst_o);

// >>> sim/tb_nss_nvm_ctrl.sv
/*
  Self-checking bench for the store controller.
  Assumes the bank model and the bound checker are compiled alongside.
*/
module tb_nss_nvm_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import nss_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i, sel_b, alt, pin, upd, srst;
  nss_reg_req_t req;
  nss_buf_req_t breq;
  logic [7:0] rdata, brd, d0, v8;
  logic [31:0] seed = 32'h90ee;
  int failures = 0;
  int cmp_count = 0;
  int upd_cnt = 0;
  int srst_cnt = 0;
  always #25 clk_i = ~clk_i;
  nss_nvm_ctrl u_nss_nvm_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .nvm_sel_b_i(sel_b), .status_alt_i(alt), .status_pin_o(pin),
    .buf_req_o(breq), .buf_rdata_i(brd), .update_o(upd), .soft_rst_o(srst));
  nss_buf_bank u_nss_buf_bank (.clk_i(clk_i), .buf_req_i(breq), .rdata_o(brd));
  // Count the event pulses.
  always @(posedge clk_i)
  begin
    if (upd === 1'b1) upd_cnt++;
    if (srst === 1'b1) srst_cnt++;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected control byte from write enable and reload bits.
  function automatic logic [7:0] ctl(logic wen, logic rl);
    return {6'h00, rl, wen};
  endfunction
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Each access ends with one idle cycle, so back-to-back calls never drive the strobe twice at once.
  task automatic wr(logic [11:0] a, logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    req = '0;
    @(negedge clk_i);
  endtask
  task automatic rchk(logic [11:0] a, logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    req = '0;
    check($sformatf("reg %h", a), rdata, e);
    @(negedge clk_i);
  endtask
  // Waits for busy to drop on the status pin, bounded.
  task automatic wait_idle();
    int n;
    for (n = 0; n < 2000 && pin !== 1'b0; n++) @(negedge clk_i);
    check("idle", {7'h00, pin}, 8'h00);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog against a hang.
  initial
  begin
    #250000;
    failures++;
    wrap_up();
  end
  initial
  begin
    rst_b_i = 1'b0;
    req = '0;
    sel_b = 1'b1;
    alt = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int a = 0; a < 4; a++) rchk(ADDR_NVM_STATUS + 12'(a), 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      v8 = 8'(xs());
      alt = v8[0];
      @(negedge clk_i);
      check("pin", {7'h00, pin}, {7'h00, alt});
      rchk({4'h3, v8}, 8'h00);
    end
    d0 = 8'(xs());
    u_nss_buf_bank.mem[12'ha01] = 8'h01;
    u_nss_buf_bank.mem[12'ha03] = OP_UPDATE;
    u_nss_buf_bank.mem[12'ha04] = OP_END;
    u_nss_buf_bank.mem[12'h100] = d0;
    // Save under write protection is dropped.
    wr(ADDR_NVM_SAVE, 8'h01);
    rchk(ADDR_NVM_SAVE, 8'h00);
    rchk(ADDR_NVM_STATUS, 8'h00);
    wr(ADDR_STATUS_PIN_CFG, 8'h80);
    wr(ADDR_NVM_CONTROL, 8'h01);
    wr(ADDR_NVM_SAVE, 8'h01);
    rchk(ADDR_NVM_STATUS, 8'h01);
    rchk(ADDR_NVM_SAVE, 8'h01);
    wait_idle();
    rchk(ADDR_NVM_SAVE, 8'h00);
    rchk(ADDR_NVM_ERROR, 8'h00);
    check("upd", 8'(upd_cnt), 8'h00);
    repeat (GAP_CYC) @(negedge clk_i);
    u_nss_buf_bank.mem[12'h100] = ~d0;
    wr(ADDR_NVM_CONTROL, 8'h03);
    rchk(ADDR_NVM_CONTROL, ctl(1'b1, 1'b0));
    sel_b = 1'b0;
    wr(ADDR_NVM_CONTROL, 8'h03);
    rchk(ADDR_NVM_CONTROL, ctl(1'b1, 1'b1));
    wait_idle();
    check("restored", u_nss_buf_bank.mem[12'h100], d0);
    check("srst", 8'(srst_cnt), 8'h01);
    check("upd", 8'(upd_cnt), 8'h01);
    rchk(ADDR_NVM_CONTROL, ctl(1'b1, 1'b0));
    rchk(ADDR_NVM_ERROR, 8'h00);
    repeat (GAP_CYC) @(negedge clk_i);
    wr(ADDR_UPDATE, 8'h01);
    @(negedge clk_i);
    check("upd", 8'(upd_cnt), 8'h02);
    rchk(ADDR_UPDATE, 8'h00);
    // A corrupted stored data byte is restored as is and caught by the closing checksum.
    u_nss_nvm_ctrl.u_mem.mem_q[3] = ~d0;
    wr(ADDR_NVM_CONTROL, 8'h03);
    rchk(ADDR_NVM_CONTROL, ctl(1'b1, 1'b1));
    wait_idle();
    check("corrupt", u_nss_buf_bank.mem[12'h100], ~d0);
    check("srst", 8'(srst_cnt), 8'h02);
    rchk(ADDR_NVM_ERROR, 8'h01);
    wr(ADDR_NVM_CONTROL, 8'h00);
    wr(ADDR_NVM_SAVE, 8'h01);
    rchk(ADDR_NVM_SAVE, 8'h00);
    wrap_up();
  end
endmodule
